// file: rtl/fcm_monitor.sv
// Fail-safe clock monitor with APB register access
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
// Function
// R1 - No failure detection before startup timer expires
// R2 - Monitor works only with enable fuse set
// R3 - Every external oscillator mode is monitored
// R4 - Sample clock is low-freq oscillator over 64
// R5 - External clock falling edge sets latch
// R6 - Sample clock rising edge clears latch
// R7 - Half sample period without low means fail
// R8 - On fail use internal clock, set flag
// R9 - Flag with enable raises interrupt
// R10 - Stay internal until software switches back
// R11 - Fallback frequency from four-bit select field
// R12 - Reset, sleep or select change clear condition
// R13 - Select change restarts timer, internal meanwhile
// R14 - Condition cleared after switch to external succeeds
// R15 - Software clears flag before switching back
// R16 - Persisting failure sets flag again
// R17 - Timer after reset/wake, skipped in EC/RC; code skips it on wake or select change only, never after reset
// R18 - Monitor enable also enables two-speed start-up
// R19 - Software checks status after start-up
// R20 - Disabled monitor never switches or flags
module fcm_monitor #(
  parameter int DIV        = fcm_pkg::LF_DIV,
  parameter int OST_EDGES  = fcm_pkg::OST_EDGES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Configuration fuses
  input  wire logic        clock_monitor_enable_fuse,
  input  wire logic [2:0]  osc_mode,
  // Sampled oscillators
  input  wire logic        ext_clk_in,
  input  wire logic        lf_osc_in,
  // Power management
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  // Clock control outputs
  output logic [1:0]       sys_src_ff,
  output logic [3:0]       int_freq_sel_ff,
  output logic             two_speed_en_ff,
  output logic             cpu_hold_ff,
  output logic             osc_fail_irq_ff
);
  localparam int DW = $clog2(DIV / 2);
  localparam int OW = $clog2(OST_EDGES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV / 2 - 1);
  localparam logic [OW-1:0] OST_LAST = OW'(OST_EDGES - 1);

  if (DIV < 4 || DIV % 2 != 0 || OST_EDGES < 1)
  begin : g_chk
    $error("fcm_monitor: bad divider or timer count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  fcm_pkg::fcm_ctrl_t   ctrl_ff;
  fcm_pkg::fcm_state_t  state_ff;
  fcm_pkg::fcm_state_t  nxt_state;
  logic                 flag_ff;
  logic                 inten_ff;
  logic                 fail_safe_ff;
  logic                 ext_q_ff;
  logic                 lf_q_ff;
  logic [DW-1:0]        div_ff;
  logic                 samp_ff;
  logic                 latch_ff;
  logic                 armed_ff;
  logic [OW-1:0]        ost_cnt_ff;
  logic                 acc;
  logic                 wr_ctrl;
  logic                 scs_chg;
  logic                 ext_fall;
  logic                 lf_rise;
  logic                 samp_rise;
  logic                 samp_fall;
  logic                 mon_on;
  logic                 fail_det;
  logic                 ost_done;
  logic                 skip_ost;
  logic [1:0]           new_scs;
  fcm_pkg::fcm_state_t  restart_st;
  logic [31:0]          rd_mux;
  logic                 rd_err;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states
  assign acc     = psel & penable & pready;
  assign wr_ctrl = acc & pwrite & (paddr == fcm_pkg::OFF_CTRL);
  assign new_scs = pwdata[fcm_pkg::CTRL_SCS_LSB +: 2];
  assign scs_chg = wr_ctrl & (new_scs != ctrl_ff.system_clock_select);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      fcm_pkg::OFF_CTRL:
      begin
        rd_mux[fcm_pkg::CTRL_SCS_LSB +: 2]  = ctrl_ff.system_clock_select;
        rd_mux[fcm_pkg::CTRL_IRCF_LSB +: 4] = ctrl_ff.ircf;
      end
      fcm_pkg::OFF_FLAG:  rd_mux[fcm_pkg::FLAG_OSF] = flag_ff;
      fcm_pkg::OFF_INTEN: rd_mux[fcm_pkg::INTEN_OSF] = inten_ff;
      fcm_pkg::OFF_STAT:
      begin
        rd_mux[fcm_pkg::STAT_EXT_RUN]   = (state_ff == fcm_pkg::ST_EXT);
        rd_mux[fcm_pkg::STAT_OST_BUSY]  = (state_ff == fcm_pkg::ST_OST);
        rd_mux[fcm_pkg::STAT_FAILSAFE]  = fail_safe_ff;
        rd_mux[fcm_pkg::STAT_MON_ON]    = mon_on;
        rd_mux[fcm_pkg::STAT_STATE +: 3] = state_ff;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Select change and fallback frequency are software controlled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff.system_clock_select  <= fcm_pkg::SCS_RST;
      ctrl_ff.ircf <= fcm_pkg::IRCF_RST;
      inten_ff     <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_ff.system_clock_select  <= new_scs;
        ctrl_ff.ircf <= pwdata[fcm_pkg::CTRL_IRCF_LSB +: 4]; // [R11]
      end
      if (acc && pwrite && paddr == fcm_pkg::OFF_INTEN)
        inten_ff <= pwdata[fcm_pkg::INTEN_OSF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock and fail detector
  assign ext_fall  = ext_q_ff & ~ext_clk_in;
  assign lf_rise   = lf_osc_in & ~lf_q_ff;
  assign samp_rise = lf_rise & (div_ff == DIV_LAST) & ~samp_ff;
  assign samp_fall = lf_rise & (div_ff == DIV_LAST) & samp_ff;
  // Any oscillator mode is watched once running on it
  assign mon_on    = clock_monitor_enable_fuse & (state_ff == fcm_pkg::ST_EXT); // [R2] [R3] [R20] [R1]
  // Armed at a sample rising edge, so only a full high phase is judged and entry mid-phase cannot false-trip
  assign fail_det  = mon_on & armed_ff & samp_fall & ~latch_ff; // [R7]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_q_ff <= 1'b0;
      lf_q_ff  <= 1'b0;
      div_ff   <= '0;
      samp_ff  <= 1'b0;
    end
    else
    begin
      ext_q_ff <= ext_clk_in;
      lf_q_ff  <= lf_osc_in;
      if (lf_rise)
      begin
        div_ff <= (div_ff == DIV_LAST) ? '0 : div_ff + 1'b1;
        if (div_ff == DIV_LAST)
          samp_ff <= ~samp_ff; // [R4]
      end
    end
  end

  // A falling edge in the clearing cycle is still counted: set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_ff <= 1'b0;
      armed_ff <= 1'b0;
    end
    else if (!mon_on)
    begin
      latch_ff <= 1'b0; // [R20]
      armed_ff <= 1'b0;
    end
    else
    begin
      if (ext_fall)
        latch_ff <= 1'b1; // [R5]
      else if (samp_rise)
        latch_ff <= 1'b0; // [R6]
      if (samp_rise)
        armed_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup timer counts external falling edges
  assign ost_done = (state_ff == fcm_pkg::ST_OST) & ext_fall & (ost_cnt_ff == OST_LAST);
  assign skip_ost = (osc_mode == fcm_pkg::MODE_EC) | (osc_mode == fcm_pkg::MODE_RC); // [R17]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ost_cnt_ff <= '0;
    else if (nxt_state != fcm_pkg::ST_OST || state_ff != fcm_pkg::ST_OST)
      ost_cnt_ff <= '0; // [R13]
    else if (ext_fall)
      ost_cnt_ff <= ost_cnt_ff + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source state machine
  always_comb
  begin
    if (wr_ctrl ? new_scs[1] : ctrl_ff.system_clock_select[1])
      restart_st = fcm_pkg::ST_INT;
    else if (skip_ost)
      restart_st = fcm_pkg::ST_EXT; // [R17]
    else
      restart_st = fcm_pkg::ST_OST; // [R13]
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      fcm_pkg::ST_OST:   if (ost_done) nxt_state = fcm_pkg::ST_EXT; // [R14]
      fcm_pkg::ST_EXT:   if (fail_det) nxt_state = fcm_pkg::ST_FAIL; // [R8] [R16]
      fcm_pkg::ST_FAIL:  nxt_state = fcm_pkg::ST_FAIL; // [R10]
      fcm_pkg::ST_INT:   nxt_state = fcm_pkg::ST_INT;
      fcm_pkg::ST_SLEEP: if (wake_req) nxt_state = restart_st; // [R17]
      default:           nxt_state = fcm_pkg::ST_OST;
    endcase
    if (scs_chg && state_ff != fcm_pkg::ST_SLEEP)
      nxt_state = restart_st; // [R12] [R13]
    if (sleep_req)
      nxt_state = fcm_pkg::ST_SLEEP; // [R12]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= fcm_pkg::ST_OST;
    else
      state_ff <= nxt_state;
  end

  // Held through the restarted timer; ends once external runs again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_safe_ff <= 1'b0; // [R12]
    else if (fail_det && !sleep_req)
      fail_safe_ff <= 1'b1;
    else if (nxt_state == fcm_pkg::ST_SLEEP || nxt_state == fcm_pkg::ST_EXT || nxt_state == fcm_pkg::ST_INT)
      fail_safe_ff <= 1'b0; // [R12] [R14]
  end

  // Hardware set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_ff <= 1'b0;
    else if (fail_det)
      flag_ff <= 1'b1; // [R8] [R16]
    else if (acc && pwrite && paddr == fcm_pkg::OFF_FLAG && pwdata[fcm_pkg::FLAG_OSF])
      flag_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_src_ff      <= fcm_pkg::SRC_INT;
      int_freq_sel_ff <= fcm_pkg::IRCF_RST;
      two_speed_en_ff <= 1'b0;
      cpu_hold_ff     <= 1'b0;
      osc_fail_irq_ff <= 1'b0;
    end
    else
    begin
      if (nxt_state == fcm_pkg::ST_EXT)
        sys_src_ff <= (ctrl_ff.system_clock_select == fcm_pkg::SCS_SEC) ? fcm_pkg::SRC_SEC : fcm_pkg::SRC_PRI;
      else
        sys_src_ff <= fcm_pkg::SRC_INT; // [R8] [R13]
      int_freq_sel_ff <= ctrl_ff.ircf; // [R11]
      two_speed_en_ff <= clock_monitor_enable_fuse; // [R18]
      // Without two-speed the core waits for the timer
      cpu_hold_ff     <= (nxt_state == fcm_pkg::ST_OST) & ~clock_monitor_enable_fuse; // [R18]
      osc_fail_irq_ff <= flag_ff & inten_ff; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A same-cycle select change or sleep takes the machine elsewhere
  sequence s_fail;
    fail_det && !scs_chg && !sleep_req;
  endsequence
  sequence s_switched;
    state_ff == fcm_pkg::ST_FAIL && sys_src_ff == fcm_pkg::SRC_INT && flag_ff;
  endsequence

  div_sample_a: assert property ($changed(samp_ff) |-> $past(lf_rise) && $past(div_ff) == DIV_LAST) // [R4]
    else $error("sample clock toggled off the divide point");
  latch_set_a: assert property (mon_on && ext_fall |=> latch_ff) // [R5]
    else $error("falling edge did not set latch");
  latch_clr_a: assert property (mon_on && samp_rise && !ext_fall |=> !latch_ff) // [R6]
    else $error("sample rise did not clear latch");
  fail_switch_a: assert property (s_fail |=> s_switched) // [R7]
    else $error("failure not followed by internal switch and flag");
  irq_raise_a: assert property ($rose(flag_ff) && inten_ff |=> osc_fail_irq_ff) // [R9]
    else $error("enabled flag gave no interrupt");
  ost_quiet_a: assert property (state_ff == fcm_pkg::ST_OST |-> !fail_det && sys_src_ff == fcm_pkg::SRC_INT) // [R1]
    else $error("detection or external clock during startup timer");
  fuse_off_a: assert property (!clock_monitor_enable_fuse |-> !fail_det && !latch_ff) // [R20]
    else $error("disabled monitor is active");
  fail_hold_a: assert property (state_ff == fcm_pkg::ST_FAIL && !scs_chg && !sleep_req |=>
    state_ff == fcm_pkg::ST_FAIL && sys_src_ff == fcm_pkg::SRC_INT) // [R10]
    else $error("left fail-safe without software action");
  sleep_clr_a: assert property (sleep_req |=> state_ff == fcm_pkg::ST_SLEEP && !fail_safe_ff) // [R12]
    else $error("sleep did not clear fail-safe");
  skip_ost_a: assert property (state_ff == fcm_pkg::ST_SLEEP && wake_req && skip_ost && !sleep_req |=>
    state_ff != fcm_pkg::ST_OST) // [R17]
    else $error("timer ran in EC or RC mode");
  two_speed_a: assert property (two_speed_en_ff |-> !cpu_hold_ff) // [R18]
    else $error("core held while two-speed enabled");
endmodule

// file: rtl/fcm_pkg.sv
// Package: register map, fields, encodings and counts of the clock monitor
package fcm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_FLAG  = 8'h04;
  localparam logic [7:0] OFF_INTEN = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0C;
  // Control register fields
  localparam int CTRL_SCS_LSB  = 0;
  localparam int CTRL_IRCF_LSB = 4;
  localparam int CTRL_SLEEP    = 8;
  // Flag, enable and status fields
  localparam int FLAG_OSF      = 0;
  localparam int INTEN_OSF     = 0;
  localparam int STAT_EXT_RUN  = 0;
  localparam int STAT_OST_BUSY = 1;
  localparam int STAT_FAILSAFE = 2;
  localparam int STAT_MON_ON   = 3;
  localparam int STAT_STATE    = 4;
  // Reset values
  localparam logic [1:0] SCS_RST  = 2'h0;
  localparam logic [3:0] IRCF_RST = 4'h7;
  // Counts
  localparam int LF_DIV    = 64;
  localparam int OST_EDGES = 1024;
  // Clock select field encodings
  localparam logic [1:0] SCS_PRI = 2'h0;
  localparam logic [1:0] SCS_SEC = 2'h1;

  typedef struct packed {
    logic [3:0] ircf;
    logic [1:0] system_clock_select;
  } fcm_ctrl_t;

  typedef enum logic [2:0] {
    ST_OST   = 3'h0,
    ST_EXT   = 3'h1,
    ST_FAIL  = 3'h2,
    ST_INT   = 3'h3,
    ST_SLEEP = 3'h4
  } fcm_state_t;

  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_PRI = 2'h1,
    SRC_SEC = 2'h2
  } fcm_src_t;

  typedef enum logic [2:0] {
    MODE_LP  = 3'h0,
    MODE_XT  = 3'h1,
    MODE_HS  = 3'h2,
    MODE_EC  = 3'h3,
    MODE_SEC = 3'h4,
    MODE_RC  = 3'h5
  } fcm_mode_t;
endpackage

// file: sim/fcm_monitor_bench.sv
// Self-checking bench for the clock monitor
`timescale 1ns/1ns
module fcm_monitor_bench;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fuse;
  logic [2:0]  osc_mode;
  logic        ext_clk_in;
  logic        lf_osc_in;
  logic        ext_run;
  logic        sleep_req;
  logic        wake_req;
  logic [1:0]  sys_src_ff;
  logic [3:0]  int_freq_sel_ff;
  logic        two_speed_en_ff;
  logic        cpu_hold_ff;
  logic        osc_fail_irq_ff;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors;
  int          total_checks;
  int          cyc;

  fcm_monitor #(.DIV(64), .OST_EDGES(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_monitor_enable_fuse(fuse),
    .osc_mode(osc_mode), .ext_clk_in(ext_clk_in), .lf_osc_in(lf_osc_in),
    .sleep_req(sleep_req), .wake_req(wake_req), .sys_src_ff(sys_src_ff),
    .int_freq_sel_ff(int_freq_sel_ff), .two_speed_en_ff(two_speed_en_ff),
    .cpu_hold_ff(cpu_hold_ff), .osc_fail_irq_ff(osc_fail_irq_ff)
  );

  fcm_osc_model u_osc (
    .pclk(pclk), .ext_run(ext_run), .ext_clk_in(ext_clk_in), .lf_osc_in(lf_osc_in)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Whole run is under two thousand cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Held until pready is sampled high; no latency assumed
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    xfer(fcm_pkg::OFF_STAT, 1'b0, 32'h0);
    while (rdata[6:4] !== s && n < 300)
    begin
      xfer(fcm_pkg::OFF_STAT, 1'b0, 32'h0);
      n++;
    end
    chk("state", {29'h0, rdata[6:4]}, {29'h0, s});
  endtask

  task automatic pulse(input logic slp);
    @(posedge pclk);
    sleep_req <= slp;
    wake_req  <= !slp;
    @(posedge pclk);
    sleep_req <= 1'b0;
    wake_req  <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    total_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    fuse = 1'b1;
    osc_mode = fcm_pkg::MODE_XT;
    ext_run = 1'b1;
    sleep_req = 1'b0;
    wake_req = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(fcm_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl", rdata, 32'h0000_0070);
    chk("fallback", {28'h0, int_freq_sel_ff}, 32'h7);
    chk("two speed", {31'h0, two_speed_en_ff}, 32'h1);
    xfer(fcm_pkg::OFF_STAT, 1'b0, 32'h0);
    chk("state", {29'h0, rdata[6:4]}, 32'h0);
    xfer(8'h10, 1'b0, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rdata, 32'h0);
    $display("test reset done");

    wait_state(3'h1);
    chk("monitor on", {31'h0, rdata[3]}, 32'h1);
    chk("source", {30'h0, sys_src_ff}, 32'h1);
    $display("test startup done");

    xfer(fcm_pkg::OFF_INTEN, 1'b1, 32'h1);
    xfer(fcm_pkg::OFF_CTRL, 1'b1, 32'h0000_00A0);
    // Output copy lags the register by one edge
    repeat (2) @(posedge pclk);
    chk("fallback", {28'h0, int_freq_sel_ff}, 32'hA);
    ext_run <= 1'b0;
    wait_state(3'h2);
    chk("failsafe", {31'h0, rdata[2]}, 32'h1);
    chk("source", {30'h0, sys_src_ff}, 32'h0);
    xfer(fcm_pkg::OFF_FLAG, 1'b0, 32'h0);
    chk("flag", rdata, 32'h1);
    chk("irq", {31'h0, osc_fail_irq_ff}, 32'h1);
    repeat (300) @(posedge pclk);
    wait_state(3'h2);
    $display("test failure done");

    // Flag cleared before switching back, as software must
    xfer(fcm_pkg::OFF_FLAG, 1'b1, 32'h1);
    xfer(fcm_pkg::OFF_FLAG, 1'b0, 32'h0);
    chk("flag", rdata, 32'h0);
    xfer(fcm_pkg::OFF_CTRL, 1'b1, 32'h0000_00A1);
    xfer(fcm_pkg::OFF_STAT, 1'b0, 32'h0);
    chk("state", {29'h0, rdata[6:4]}, 32'h0);
    chk("source", {30'h0, sys_src_ff}, 32'h0);
    ext_run <= 1'b1;
    wait_state(3'h1);
    chk("failsafe", {31'h0, rdata[2]}, 32'h0);
    chk("source", {30'h0, sys_src_ff}, 32'h2);
    ext_run <= 1'b0;
    wait_state(3'h2);
    xfer(fcm_pkg::OFF_FLAG, 1'b0, 32'h0);
    chk("flag", rdata, 32'h1);
    $display("test switch back done");

    ext_run <= 1'b1;
    for (int m = 0; m < 6; m++)
    begin
      osc_mode <= m[2:0];
      pulse(1'b1);
      wait_state(3'h4);
      pulse(1'b0);
      xfer(fcm_pkg::OFF_STAT, 1'b0, 32'h0);
      chk("wake", {29'h0, rdata[6:4]}, (m == 3 || m == 5) ? 32'h1 : 32'h0);
      wait_state(3'h1);
    end
    $display("test modes done");

    // Second reset mid-run, monitor disabled
    fuse <= 1'b0;
    osc_mode <= fcm_pkg::MODE_XT;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("hold", {31'h0, cpu_hold_ff}, 32'h1);
    chk("two speed", {31'h0, two_speed_en_ff}, 32'h0);
    xfer(fcm_pkg::OFF_FLAG, 1'b0, 32'h0);
    chk("flag", rdata, 32'h0);
    wait_state(3'h1);
    ext_run <= 1'b0;
    repeat (400) @(posedge pclk);
    wait_state(3'h1);
    chk("monitor off", {31'h0, rdata[3]}, 32'h0);
    xfer(fcm_pkg::OFF_FLAG, 1'b0, 32'h0);
    chk("flag", rdata, 32'h0);
    chk("source", {30'h0, sys_src_ff}, 32'h1);
    $display("test disabled done");
    finish_test();
  end
endmodule

// file: sim/fcm_osc_model.sv
// Behavioural external and low-frequency oscillators
`timescale 1ns/1ns
module fcm_osc_model (
  // Control
  input  wire logic pclk,
  input  wire logic ext_run,
  // Oscillator levels
  output logic      ext_clk_in,
  output logic      lf_osc_in
);
  logic [1:0] ext_cnt_ff;

  initial
  begin
    ext_clk_in = 1'b1;
    lf_osc_in  = 1'b0;
    ext_cnt_ff = 2'h0;
  end

  // A dead crystal parks high, so no falling edge reaches the detector
  always @(posedge pclk)
  begin
    lf_osc_in  <= ~lf_osc_in;
    ext_cnt_ff <= ext_cnt_ff + 2'h1;
    if (!ext_run)
      ext_clk_in <= 1'b1;
    else if (ext_cnt_ff[0])
      ext_clk_in <= ~ext_clk_in;
  end
endmodule
